// ### transfer_cfg.svh
// constants for the data transfer execution block
`ifndef TRANSFER_CFG_SVH
`define TRANSFER_CFG_SVH

// ----------------------------------------------------------------------
// register file, flag register and pointers
// ----------------------------------------------------------------------
`define REG_RST      8'h00
`define FLAG_RST     8'h00
`define PTR_X_LO     5'h1A
`define PTR_X_HI     5'h1B
`define PTR_Y_LO     5'h1C
`define PTR_Y_HI     5'h1D
`define PTR_Z_LO     5'h1E
`define PTR_Z_HI     5'h1F
`define SEL_X        2'h0
`define SEL_Y        2'h1
`define SEL_Z        2'h2
`define HALF_MASK    8'h20

// ----------------------------------------------------------------------
// opcodes
// ----------------------------------------------------------------------
`define OPC_HCLR     16'h94D8
`define OPC_COPY     6'h0B
`define OPC_PAIR     8'h01
`define OPC_IMM      4'hE
`define OPC_MEMGRP   6'h24
`define OPC_DISP     2'h2

`endif

// ### transfer_pkg.sv
// types shared by the data transfer execution block
package transfer_pkg;
   typedef enum logic [2:0] {
      op_none, op_reg_copy, op_pair_copy, op_immediate_load,
      op_half_carry_clear, op_indirect_load, op_direct_fetch, op_indirect_write
   } op_t;
   typedef enum logic [1:0] {mode_plain, mode_post, mode_pre, mode_disp} ptr_mode_t;
   typedef enum logic {state_idle, state_wait} state_t;
endpackage : transfer_pkg

// ### data_transfer_instr_exec.sv
// executes the data transfer instruction group against its own register file
`timescale 1ns/10ps
`include "transfer_cfg.svh"
module data_transfer_instr_exec (
   input  wire logic        mclk,
   input  wire logic        nrst,
   input  wire logic        instr_valid,
   input  wire logic [15:0] instr_word,
   input  wire logic [15:0] instr_ext,
   output logic             ready,
   output logic             insn_unknown,
   output logic [15:0]      mem_addr,
   output logic [7:0]       mem_wdata,
   output logic             mem_we,
   output logic             mem_re,
   input  wire logic [7:0]  mem_rdata,
   output logic [7:0]       flag_register,
   input  wire logic [4:0]  peek_idx,
   output logic [7:0]       peek_data
);
   import transfer_pkg::*;

   // ----------------------------------------------------------------------
   // reset release
   // ----------------------------------------------------------------------
   logic rst_meta;
   logic rst_n;
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         rst_meta <= 1'b0;
         rst_n    <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n    <= rst_meta;
      end
   end

   // ----------------------------------------------------------------------
   // functions
   // ----------------------------------------------------------------------
   function automatic logic [15:0] pick_ptr(input logic [1:0] sel, input logic [15:0] x,
                                            input logic [15:0] y, input logic [15:0] z);
      pick_ptr = (sel == `SEL_X) ? x : ((sel == `SEL_Y) ? y : z);
   endfunction : pick_ptr

   // {valid, pointer select, mode} from the low nibble of a memory group word
   function automatic logic [4:0] decode_ind(input logic [3:0] low);
      case (low)
         4'hC: decode_ind = {1'b1, `SEL_X, mode_plain};
         4'hD: decode_ind = {1'b1, `SEL_X, mode_post};
         4'hE: decode_ind = {1'b1, `SEL_X, mode_pre};
         4'h9: decode_ind = {1'b1, `SEL_Y, mode_post};
         4'hA: decode_ind = {1'b1, `SEL_Y, mode_pre};
         4'h1: decode_ind = {1'b1, `SEL_Z, mode_post};
         4'h2: decode_ind = {1'b1, `SEL_Z, mode_pre};
         default: decode_ind = 5'h00;
      endcase
   endfunction : decode_ind

   // ----------------------------------------------------------------------
   // decode
   // ----------------------------------------------------------------------
   logic [7:0]  regs [32];
   logic [7:0]  next_regs [32];
   state_t      state;
   logic [4:0]  wait_dst;
   logic        wait_load;

   wire         is_copy   = (instr_word[15:10] == `OPC_COPY);
   wire         is_pair   = (instr_word[15:8] == `OPC_PAIR);
   wire         is_imm    = (instr_word[15:12] == `OPC_IMM);
   wire         is_hclr   = (instr_word == `OPC_HCLR);
   wire         is_grp    = (instr_word[15:10] == `OPC_MEMGRP);
   wire         is_disp   = (instr_word[15:14] == `OPC_DISP) && !instr_word[12];
   wire [4:0]   ind_dec   = decode_ind(instr_word[3:0]);
   wire         is_direct = is_grp && !instr_word[9] && (instr_word[3:0] == 4'h0);
   wire         is_ind    = (is_grp && ind_dec[4]) || is_disp;
   wire         is_store  = instr_word[9];
   wire [4:0]   dst_idx   = instr_word[8:4];
   wire [4:0]   src_idx   = {instr_word[9], instr_word[3:0]};
   wire [4:0]   imm_dst   = {1'b1, instr_word[7:4]};
   wire [7:0]   imm_k     = {instr_word[11:8], instr_word[3:0]};
   wire [4:0]   pair_d    = {instr_word[7:4], 1'b0};
   wire [4:0]   pair_d_hi = {instr_word[7:4], 1'b1};
   wire [4:0]   pair_s    = {instr_word[3:0], 1'b0};
   wire [4:0]   pair_s_hi = {instr_word[3:0], 1'b1};
   wire [5:0]   disp      = {instr_word[13], instr_word[11:10], instr_word[2:0]};
   wire [1:0]   ptr_sel   = is_disp ? (instr_word[3] ? `SEL_Y : `SEL_Z) : ind_dec[3:2];
   wire [1:0]   mode_bits = is_disp ? mode_disp : ind_dec[1:0];
   wire ptr_mode_t ptr_mode = ptr_mode_t'(mode_bits);

   wire op_t op = is_hclr   ? op_half_carry_clear :
                  is_copy   ? op_reg_copy :
                  is_pair   ? op_pair_copy :
                  is_imm    ? op_immediate_load :
                  is_direct ? op_direct_fetch :
                  (is_ind && is_store) ? op_indirect_write :
                  is_ind    ? op_indirect_load : op_none;

   // ----------------------------------------------------------------------
   // pointers and addresses
   // ----------------------------------------------------------------------
   wire [15:0]  ptr_x    = {regs[`PTR_X_HI], regs[`PTR_X_LO]};
   wire [15:0]  ptr_y    = {regs[`PTR_Y_HI], regs[`PTR_Y_LO]};
   wire [15:0]  ptr_z    = {regs[`PTR_Z_HI], regs[`PTR_Z_LO]};
   wire [15:0]  ptr_cur  = pick_ptr(ptr_sel, ptr_x, ptr_y, ptr_z);
   wire [15:0]  ptr_inc  = ptr_cur + 16'h0001;
   wire [15:0]  ptr_dec  = ptr_cur - 16'h0001;
   wire [4:0]   ptr_lo   = (ptr_sel == `SEL_X) ? `PTR_X_LO :
                           ((ptr_sel == `SEL_Y) ? `PTR_Y_LO : `PTR_Z_LO);
   wire [4:0]   ptr_hi   = {ptr_lo[4:1], 1'b1};
   wire [15:0]  ptr_new  = (ptr_mode == mode_pre) ? ptr_dec : ptr_inc;
   wire         ptr_step = (ptr_mode == mode_post) || (ptr_mode == mode_pre);
   wire [15:0]  eff_addr = (ptr_mode == mode_pre)  ? ptr_dec :
                           (ptr_mode == mode_disp) ? ptr_cur + {10'h000, disp} :
                           ptr_cur;
   wire         accept   = instr_valid && ready;
   wire         mem_op   = (op == op_indirect_load) || (op == op_direct_fetch) ||
                           (op == op_indirect_write);
   wire [7:0]   src_val  = regs[src_idx];
   wire [7:0]   store_val = regs[dst_idx];

   // ----------------------------------------------------------------------
   // register file update
   // ----------------------------------------------------------------------
   always_comb begin
      next_regs = regs;
      if (state == state_wait && wait_load) begin
         next_regs[wait_dst] = mem_rdata;
      end
      if (accept) begin
         case (op)
            op_reg_copy: next_regs[dst_idx] = src_val;
            op_pair_copy: begin
               next_regs[pair_d]    = regs[pair_s];
               next_regs[pair_d_hi] = regs[pair_s_hi];
            end
            op_immediate_load: next_regs[imm_dst] = imm_k;
            op_indirect_load, op_indirect_write: begin
               if (ptr_step) begin
                  next_regs[ptr_lo] = ptr_new[7:0];
                  next_regs[ptr_hi] = ptr_new[15:8];
               end
            end
            default: ;
         endcase
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < 32; i++) begin
            regs[i] <= `REG_RST;
         end
      end else begin
         regs <= next_regs;
      end
   end

   // ----------------------------------------------------------------------
   // sequencing and memory port
   // ----------------------------------------------------------------------
   wire state_t next_state = (accept && mem_op) ? state_wait : state_idle;
   wire [7:0]   next_flag  = (accept && op == op_half_carry_clear) ?
                             (flag_register & ~`HALF_MASK) : flag_register;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         state         <= state_idle;
         ready         <= 1'b0;
         insn_unknown  <= 1'b0;
         wait_dst      <= 5'h00;
         wait_load     <= 1'b0;
         mem_addr      <= 16'h0000;
         mem_wdata     <= 8'h00;
         mem_we        <= 1'b0;
         mem_re        <= 1'b0;
         flag_register <= `FLAG_RST;
         peek_data     <= 8'h00;
      end else begin
         state         <= next_state;
         ready         <= (next_state == state_idle);
         insn_unknown  <= accept && (op == op_none);
         wait_dst      <= dst_idx;
         wait_load     <= accept && (op == op_indirect_load || op == op_direct_fetch);
         mem_re        <= accept && (op == op_indirect_load || op == op_direct_fetch);
         mem_we        <= accept && (op == op_indirect_write);
         if (accept && mem_op) begin
            mem_addr  <= (op == op_direct_fetch) ? instr_ext : eff_addr;
            mem_wdata <= store_val;
         end
         flag_register <= next_flag;
         peek_data     <= next_regs[peek_idx];
      end
   end

   // ----------------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   chk_hclr_flag: assert property (
      accept && op == op_half_carry_clear |=>
         flag_register == ($past(flag_register) & ~`HALF_MASK))
      else $error("half carry clear wrong");
   chk_flags_kept: assert property (
      accept && op != op_half_carry_clear |=> $stable(flag_register))
      else $error("flags changed by transfer");
   chk_copy_one: assert property (
      accept && op == op_reg_copy |=> regs[$past(dst_idx)] == $past(src_val) && ready)
      else $error("register copy wrong");
   chk_pair_both: assert property (
      accept && op == op_pair_copy |=>
         regs[$past(pair_d)] == $past(regs[pair_s]) &&
         regs[$past(pair_d_hi)] == $past(regs[pair_s_hi]))
      else $error("pair copy wrong");
   chk_imm_value: assert property (
      accept && op == op_immediate_load |=> regs[$past(imm_dst)] == $past(imm_k))
      else $error("immediate load wrong");
   chk_post_inc: assert property (
      accept && op == op_indirect_load && ptr_mode == mode_post |=>
         mem_re && mem_addr == $past(ptr_cur) &&
         pick_ptr($past(ptr_sel), ptr_x, ptr_y, ptr_z) == $past(ptr_cur) + 16'h0001)
      else $error("post increment wrong");
   chk_pre_dec: assert property (
      accept && op == op_indirect_load && ptr_mode == mode_pre |=>
         mem_addr == $past(ptr_cur) - 16'h0001 &&
         pick_ptr($past(ptr_sel), ptr_x, ptr_y, ptr_z) == mem_addr)
      else $error("pre decrement wrong");
   chk_disp_addr: assert property (
      accept && op == op_indirect_load && ptr_mode == mode_disp |=>
         mem_addr == $past(ptr_cur) + {10'h000, $past(disp)} &&
         pick_ptr($past(ptr_sel), ptr_x, ptr_y, ptr_z) == $past(ptr_cur))
      else $error("displacement load wrong");
   chk_direct_addr: assert property (
      accept && op == op_direct_fetch |=> mem_re && mem_addr == $past(instr_ext) && !ready)
      else $error("direct load address wrong");
   chk_load_data: assert property (
      mem_re |=> regs[$past(wait_dst)] == $past(mem_rdata) && ready)
      else $error("load data not written");
   chk_store_write: assert property (
      accept && op == op_indirect_write |=>
         mem_we && mem_wdata == $past(store_val) && !ready ##1 !mem_we && ready)
      else $error("store wrong");

   cov_copy:  cover property (accept && op == op_reg_copy);
   cov_post:  cover property (accept && op == op_indirect_load && ptr_mode == mode_post);
   cov_store: cover property (accept && op == op_indirect_write ##2 accept);
   cov_hclr:  cover property (accept && op == op_half_carry_clear);
endmodule : data_transfer_instr_exec

// ### data_mem_model.sv
// data memory partner model for the data transfer execution block
`timescale 1ns/10ps
module data_mem_model (
   input  wire logic        mclk,
   input  wire logic [15:0] mem_addr,
   input  wire logic [7:0]  mem_wdata,
   input  wire logic        mem_we,
   input  wire logic        mem_re,
   output logic [7:0]       mem_rdata
);
   // ----------------------------------------------------------------------
   // storage and read path
   // ----------------------------------------------------------------------
   logic [7:0] cells [0:65535];
   logic [7:0] idle_pat = 8'h5A;

   // outside a read the bus shows a changing pattern, never the last byte
   assign mem_rdata = mem_re ? cells[mem_addr] : idle_pat;

   always @(posedge mclk) begin
      idle_pat <= ~idle_pat;
      if (mem_we) begin
         cells[mem_addr] <= mem_wdata;
      end
   end
endmodule : data_mem_model

// ### data_transfer_instr_exec_tb.sv
// self-checking testbench for the data transfer execution block
`timescale 1ns/10ps
module data_transfer_instr_exec_tb;
   // ----------------------------------------------------------------------
   // signals and instances
   // ----------------------------------------------------------------------
   logic        mclk = 1'b0;
   logic        nrst = 1'b0;
   logic        instr_valid = 1'b0;
   logic [15:0] instr_word = 16'h0000;
   logic [15:0] instr_ext = 16'h0000;
   logic        ready;
   logic        insn_unknown;
   logic [15:0] mem_addr;
   logic [7:0]  mem_wdata;
   logic        mem_we;
   logic        mem_re;
   logic [7:0]  mem_rdata;
   logic [7:0]  flag_register;
   logic [4:0]  peek_idx = 5'h00;
   logic [7:0]  peek_data;
   int          err_total = 0;
   int          checks_done = 0;

   data_transfer_instr_exec u_data_transfer_instr_exec (
      .mclk(mclk), .nrst(nrst), .instr_valid(instr_valid), .instr_word(instr_word),
      .instr_ext(instr_ext), .ready(ready), .insn_unknown(insn_unknown),
      .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_we(mem_we), .mem_re(mem_re),
      .mem_rdata(mem_rdata), .flag_register(flag_register), .peek_idx(peek_idx),
      .peek_data(peek_data));

   data_mem_model u_data_mem_model (
      .mclk(mclk), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_we(mem_we),
      .mem_re(mem_re), .mem_rdata(mem_rdata));

   initial begin
      forever #4 mclk = ~mclk;
   end

   // ----------------------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------------------
   task results;
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : results

   task chk_val(input string n, input logic [15:0] e, input logic [15:0] g);
      checks_done++;
      if (g !== e) begin
         err_total++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask : chk_val

   task chk_reg(input logic [4:0] i, input logic [7:0] e);
      peek_idx = i;
      @(posedge mclk);
      #1;
      chk_val($sformatf("reg%0d", i), {8'h00, e}, {8'h00, peek_data});
   endtask : chk_reg

   // offers one word after an idle edge when ready; returns 1 ns after the edge on which it was taken
   task issue(input logic [15:0] w, input logic [15:0] e);
      int n;
      n = 0;
      @(posedge mclk);
      #1;
      while (ready !== 1'b1 && n < 20) begin
         @(posedge mclk);
         #1;
         n++;
      end
      if (ready !== 1'b1) begin
         err_total++;
         results();
      end
      instr_valid = 1'b1;
      instr_word = w;
      instr_ext = e;
      @(posedge mclk);
      #1;
      instr_valid = 1'b0;
   endtask : issue

   // ----------------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------------
   task t_moves;
      issue(16'hEA05, 16'h0000);
      issue(16'hE31C, 16'h0000);
      issue(16'h2E10, 16'h0000);
      issue(16'h0118, 16'h0000);
      chk_reg(5'h01, 8'hA5);
      chk_reg(5'h02, 8'hA5);
      chk_reg(5'h03, 8'h3C);
      chk_reg(5'h11, 8'h3C);
   endtask : t_moves

   task t_ptr_x;
      issue(16'hEFAF, 16'h0000);
      issue(16'hE1B2, 16'h0000);
      issue(16'h930D, 16'h0000);
      chk_val("we", 16'h0001, {15'h0000, mem_we});
      chk_val("addr", 16'h12FF, mem_addr);
      chk_val("wdata", 16'h00A5, {8'h00, mem_wdata});
      chk_reg(5'h1A, 8'h00);
      chk_reg(5'h1B, 8'h13);
      issue(16'h914E, 16'h0000);
      chk_val("re", 16'h0001, {15'h0000, mem_re});
      chk_val("ready", 16'h0000, {15'h0000, ready});
      chk_val("addr", 16'h12FF, mem_addr);
      chk_reg(5'h14, 8'hA5);
      chk_reg(5'h1B, 8'h12);
      issue(16'h914D, 16'h0000);
      chk_val("addr", 16'h12FF, mem_addr);
      chk_reg(5'h1A, 8'h00);
   endtask : t_ptr_x

   task t_disp;
      issue(16'hE1C0, 16'h0000);
      issue(16'hE2D0, 16'h0000);
      issue(16'hAF0F, 16'h0000);
      chk_val("addr", 16'h204F, mem_addr);
      issue(16'hAD5F, 16'h0000);
      chk_val("addr", 16'h204F, mem_addr);
      chk_reg(5'h15, 8'hA5);
      chk_reg(5'h1C, 8'h10);
   endtask : t_disp

   task t_ptr_zy;
      issue(16'hEFEF, 16'h0000);
      issue(16'hE2F0, 16'h0000);
      issue(16'h9301, 16'h0000);
      chk_val("addr", 16'h20FF, mem_addr);
      chk_reg(5'h1F, 8'h21);
      issue(16'h9172, 16'h0000);
      chk_val("addr", 16'h20FF, mem_addr);
      chk_reg(5'h17, 8'hA5);
      chk_reg(5'h1F, 8'h20);
      issue(16'h8180, 16'h0000);
      chk_val("addr", 16'h20FF, mem_addr);
      chk_reg(5'h18, 8'hA5);
      chk_reg(5'h1E, 8'hFF);
      issue(16'h9309, 16'h0000);
      chk_val("addr", 16'h2010, mem_addr);
      issue(16'h919A, 16'h0000);
      chk_val("addr", 16'h2010, mem_addr);
      chk_reg(5'h19, 8'hA5);
      chk_reg(5'h1C, 8'h10);
      issue(16'h930C, 16'h0000);
      chk_val("addr", 16'h1300, mem_addr);
      chk_reg(5'h1A, 8'h00);
   endtask : t_ptr_zy

   task t_direct;
      issue(16'h9160, 16'h204F);
      chk_val("re", 16'h0001, {15'h0000, mem_re});
      chk_val("addr", 16'h204F, mem_addr);
      chk_reg(5'h16, 8'hA5);
   endtask : t_direct

   task t_flags;
      chk_val("flags", 16'h0000, {8'h00, flag_register});
      issue(16'h94D8, 16'h0000);
      chk_val("flags", 16'h0000, {8'h00, flag_register});
      issue(16'hFFFF, 16'h0000);
      chk_val("unknown", 16'h0001, {15'h0000, insn_unknown});
   endtask : t_flags

   // ----------------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------------
   initial begin
      repeat (20) @(posedge mclk);
      #1;
      nrst = 1'b1;
      t_moves();
      t_ptr_x();
      t_disp();
      t_ptr_zy();
      t_direct();
      t_flags();
      results();
   end
endmodule : data_transfer_instr_exec_tb
